// File: src/fill_bus_pkg.sv
// Shared constants and check-bit function for the cache fill bus
package fill_bus_pkg;
	// ----------------------------------------------------------------
	// Bus widths
	// ----------------------------------------------------------------
	localparam int DATA_W = 128;
	localparam int CHECK_W = 16;
	localparam int INDEX_W = 22;
	localparam int INDEX_LO = 4;
	localparam int INDEX_HI = 25;
	// ----------------------------------------------------------------
	// Fill sequencing
	// ----------------------------------------------------------------
	localparam int FILL_BEATS = 2;
	localparam logic [1:0] LAST_BEAT = 2'h1;
	localparam int QUIET_CYCLES = 4;
	localparam logic [3:0] QUIET_LAST = 4'(QUIET_CYCLES - 1);
	// ----------------------------------------------------------------
	// Controller register map and fields
	// ----------------------------------------------------------------
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_STATUS = 5'h04;
	localparam logic [4:0] REG_MASK = 5'h08;
	localparam logic [4:0] REG_MISS0 = 5'h0C;
	localparam logic [4:0] REG_MISS1 = 5'h10;
	localparam int CTRL_ECC_BIT = 0;
	localparam int EV_TRAP = 0;
	localparam int EV_CHECK = 1;
	localparam int EV_DONE = 2;
	localparam int EV_W = 3;
	localparam int STAT_BUSY_BIT = 8;
	// ----------------------------------------------------------------
	// Check code: even byte parity, or an 8-bit code per 64-bit group
	// ----------------------------------------------------------------
	localparam logic [7:0][63:0] ECC_MASK = {
		64'h6996966996696996, 64'hFFFFFFFFFFFFFFFF,
		64'hFFFFFFFF00000000, 64'hFFFF0000FFFF0000,
		64'hFF00FF00FF00FF00, 64'hF0F0F0F0F0F0F0F0,
		64'hCCCCCCCCCCCCCCCC, 64'hAAAAAAAAAAAAAAAA};

	function automatic logic [CHECK_W-1:0] check_bits(input logic [DATA_W-1:0] d,
		input logic ecc);
		logic [CHECK_W-1:0] c;
		c = '0;
		for (int i = 0; i < CHECK_W; i++) begin
			if (ecc) begin
				c[i] = ^(d[64*(i/8) +: 64] & ECC_MASK[i%8]);
			end else begin
				c[i] = ^d[8*i +: 8];
			end
		end
		return c;
	endfunction : check_bits
endpackage : fill_bus_pkg

// File: src/fill_bus_if.sv
// Interface joining the processor end and the system end of the fill bus
`timescale 1ns/1ns
interface fill_bus_if;
	import fill_bus_pkg::*;
	// Shared data and check wires, one driver side each
	logic [DATA_W-1:0] dev_data;
	logic [DATA_W-1:0] sys_data;
	logic dev_data_oe_b;
	logic sys_data_oe_b;
	logic [CHECK_W-1:0] dev_check;
	logic [CHECK_W-1:0] sys_check;
	logic [DATA_W-1:0] data;
	logic [CHECK_W-1:0] check;
	// System to processor controls
	logic data_bus_req;
	logic fill_warning;
	logic fill_miss_select;
	logic fill_error;
	logic fill_nocheck;
	logic data_ack;
	logic cache_idle_request;
	// Processor to cache RAM
	logic data_ram_oe;
	logic data_ram_we;
	logic [INDEX_W-1:0] cache_index;

	// Wire level from the enables
	assign data = !dev_data_oe_b ? dev_data : (!sys_data_oe_b ? sys_data : '0);
	assign check = !dev_data_oe_b ? dev_check : (!sys_data_oe_b ? sys_check : '0);

	modport dev (
		input data, check, data_bus_req, fill_warning, fill_miss_select,
		input fill_error, fill_nocheck, data_ack, cache_idle_request,
		output dev_data, dev_check, dev_data_oe_b,
		output data_ram_oe, data_ram_we, cache_index
	);
	modport sys (
		input data, check, data_ram_oe, data_ram_we, cache_index,
		output sys_data, sys_check, sys_data_oe_b,
		output data_bus_req, fill_warning, fill_miss_select,
		output fill_error, fill_nocheck, data_ack, cache_idle_request
	);
endinterface : fill_bus_if

// File: src/cache_fill_ctrl.sv
// Processor end: data bus hand-off, fill sequencing and cache RAM control
`timescale 1ns/1ns
module cache_fill_ctrl
	import fill_bus_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Fill bus
	fill_bus_if.dev bus,
	// Register port
	input wire logic [4:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq,
	// Cache access requests
	input wire logic cache_rd_req,
	input wire logic cache_wr_req,
	input wire logic [INDEX_W-1:0] op_index,
	input wire logic [DATA_W-1:0] op_wdata,
	output logic op_ack,
	// Returned data and events
	output logic [DATA_W-1:0] cache_data,
	output logic cache_data_valid,
	output logic fill_data_valid,
	output logic check_error,
	output logic machine_check_trap
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_READ,
		ST_WRITE,
		ST_FILL,
		ST_FILL_WAIT
	} ctrl_state_t;

	typedef struct packed {
		ctrl_state_t state;
		logic data_oe_b;
		logic [DATA_W-1:0] data_out;
		logic [CHECK_W-1:0] check_out;
		logic ram_oe;
		logic ram_we;
		logic [INDEX_W-1:0] index;
		logic [1:0] beat;
		logic ecc;
		logic [INDEX_W-1:0] miss0;
		logic [INDEX_W-1:0] miss1;
		logic [EV_W-1:0] status;
		logic [EV_W-1:0] mask;
		logic [31:0] rdata;
		logic irq;
		logic op_ack;
		logic [DATA_W-1:0] cache_data;
		logic cache_valid;
		logic fill_valid;
		logic chk_err;
		logic trap;
	} ctrl_reg_t;

	ctrl_reg_t s;
	ctrl_reg_t next_s;
	logic [EV_W-1:0] ev;
	logic bad_check;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		ev = '0;
		next_s.op_ack = 1'b0;
		next_s.cache_valid = 1'b0;
		next_s.fill_valid = 1'b0;
		next_s.chk_err = 1'b0;
		next_s.trap = 1'b0;
		next_s.rdata = '0;
		bad_check = (check_bits(bus.data, s.ecc) != bus.check);

		// Bus hand-off follows the sampled request by one edge
		next_s.data_oe_b = bus.data_bus_req;

		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				REG_CTRL: next_s.ecc = reg_wdata[CTRL_ECC_BIT];
				REG_MASK: next_s.mask = reg_wdata[EV_W-1:0];
				REG_MISS0: next_s.miss0 = reg_wdata[INDEX_HI:INDEX_LO];
				REG_MISS1: next_s.miss1 = reg_wdata[INDEX_HI:INDEX_LO];
				default: ;
			endcase
		end

		// Register reads, data valid the cycle after the strobe
		if (reg_rd) begin
			case (reg_addr)
				REG_CTRL: next_s.rdata[CTRL_ECC_BIT] = s.ecc;
				REG_STATUS: begin
					next_s.rdata[EV_W-1:0] = s.status;
					next_s.rdata[STAT_BUSY_BIT] = (s.state != ST_IDLE);
					next_s.status = '0;
				end
				REG_MASK: next_s.rdata[EV_W-1:0] = s.mask;
				REG_MISS0: next_s.rdata[INDEX_HI:INDEX_LO] = s.miss0;
				REG_MISS1: next_s.rdata[INDEX_HI:INDEX_LO] = s.miss1;
				default: ;
			endcase
		end

		// Cache and fill sequencing
		case (s.state)
			ST_IDLE: begin
				if (bus.fill_warning) begin
					// Miss address to the cache, write starts next edge
					next_s.index = bus.fill_miss_select ? s.miss1 : s.miss0;
					next_s.ram_we = 1'b1;
					next_s.beat = '0;
					next_s.state = ST_FILL;
				end else if (!bus.cache_idle_request) begin
					if (cache_rd_req) begin
						next_s.index = op_index;
						next_s.ram_oe = 1'b1;
						next_s.op_ack = 1'b1;
						next_s.state = ST_READ;
					end else if (cache_wr_req && !s.data_oe_b && !bus.data_bus_req) begin
						next_s.index = op_index;
						next_s.ram_we = 1'b1;
						next_s.data_out = op_wdata;
						next_s.check_out = check_bits(op_wdata, s.ecc);
						next_s.op_ack = 1'b1;
						next_s.state = ST_WRITE;
					end
				end
			end
			ST_READ: begin
				// RAM data stands on the bus now
				next_s.cache_data = bus.data;
				next_s.cache_valid = 1'b1;
				next_s.chk_err = bad_check;
				next_s.ram_oe = 1'b0;
				next_s.state = ST_IDLE;
			end
			ST_WRITE: begin
				next_s.ram_we = 1'b0;
				next_s.state = ST_IDLE;
			end
			ST_FILL: begin
				if (bus.data_ack) begin
					// Data cycle: all fill inputs taken on this edge
					next_s.cache_data = bus.data;
					next_s.fill_valid = 1'b1;
					next_s.chk_err = bad_check && !bus.fill_nocheck;
					next_s.trap = bus.fill_error;
					next_s.beat = s.beat + 2'h1;
					if (s.beat == LAST_BEAT) begin
						next_s.ram_we = 1'b0;
						ev[EV_DONE] = 1'b1;
						next_s.state = ST_IDLE;
					end else begin
						next_s.index = s.index + 22'h1;
					end
				end else begin
					// No acknowledge: drop the write for one clock
					next_s.ram_we = 1'b0;
					next_s.state = ST_FILL_WAIT;
				end
			end
			ST_FILL_WAIT: begin
				next_s.ram_we = 1'b1;
				next_s.state = ST_FILL;
			end
			default: next_s.state = ST_IDLE;
		endcase

		// Sticky events: a set wins over the read clear
		ev[EV_TRAP] = next_s.trap;
		ev[EV_CHECK] = next_s.chk_err;
		next_s.status = next_s.status | ev;
		next_s.irq = |(next_s.status & next_s.mask);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s <= '0;
			s.data_oe_b <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign bus.dev_data = s.data_out;
	assign bus.dev_check = s.check_out;
	assign bus.dev_data_oe_b = s.data_oe_b;
	assign bus.data_ram_oe = s.ram_oe;
	assign bus.data_ram_we = s.ram_we;
	assign bus.cache_index = s.index;
	assign reg_rdata = s.rdata;
	assign irq = s.irq;
	assign op_ack = s.op_ack;
	assign cache_data = s.cache_data;
	assign cache_data_valid = s.cache_valid;
	assign fill_data_valid = s.fill_valid;
	assign check_error = s.chk_err;
	assign machine_check_trap = s.trap;
endmodule : cache_fill_ctrl

// File: src/fill_sys_end.sv
// System end: idles the cache, takes the bus and returns fill data
`timescale 1ns/1ns
module fill_sys_end
	import fill_bus_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Fill bus
	fill_bus_if.sys bus,
	// Fill orders
	input wire logic fill_go,
	input wire logic fill_slot,
	input wire logic fill_bad,
	input wire logic skip_check,
	input wire logic ecc_mode,
	input wire logic beat_stall,
	input wire logic [DATA_W-1:0] beat_data,
	output logic [1:0] beat_num,
	output logic fill_busy,
	output logic fill_done
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SY_IDLE,
		SY_QUIET,
		SY_TAKE,
		SY_BEAT,
		SY_HOLD,
		SY_DROP,
		SY_DONE
	} sys_state_t;

	typedef struct packed {
		sys_state_t state;
		logic [3:0] cnt;
		logic idle_req;
		logic bus_req;
		logic warn;
		logic sel;
		logic bad;
		logic data_oe_b;
		logic [DATA_W-1:0] data_out;
		logic [CHECK_W-1:0] check_out;
		logic ack;
		logic err;
		logic nocheck;
		logic [1:0] beat;
		logic busy;
		logic done;
	} sys_reg_t;

	sys_reg_t s;
	sys_reg_t next_s;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		next_s.warn = 1'b0;
		next_s.busy = (s.state != SY_IDLE) || fill_go;
		case (s.state)
			SY_IDLE: begin
				if (fill_go) begin
					next_s.sel = fill_slot;
					next_s.bad = fill_bad;
					next_s.idle_req = 1'b1;
					next_s.cnt = '0;
					next_s.state = SY_QUIET;
				end
			end
			SY_QUIET: begin
				next_s.cnt = s.cnt + 4'h1;
				if (s.cnt == QUIET_LAST) begin
					next_s.bus_req = 1'b1;
					next_s.state = SY_TAKE;
				end
			end
			SY_TAKE: begin
				next_s.warn = 1'b1;
				next_s.beat = '0;
				next_s.state = SY_BEAT;
			end
			SY_BEAT: begin
				// Present a data cycle with correct check bits, beats back to back
				next_s.data_oe_b = 1'b0;
				next_s.data_out = beat_data;
				next_s.check_out = check_bits(beat_data, ecc_mode);
				next_s.ack = !beat_stall;
				next_s.err = s.bad && !beat_stall && (s.beat == 2'h0);
				next_s.nocheck = skip_check;
				if (beat_stall) begin
					// Refused cycle: the processor skips one edge before it looks again
					next_s.state = SY_HOLD;
				end else if (s.beat == LAST_BEAT) begin
					next_s.state = SY_DROP;
				end else begin
					next_s.beat = s.beat + 2'h1;
				end
			end
			SY_HOLD: begin
				// Processor is in its wait cycle, keep the data and no acknowledge
				next_s.ack = 1'b0;
				next_s.err = 1'b0;
				next_s.state = SY_BEAT;
			end
			SY_DROP: begin
				// Last beat taken: let go of the bus and the idle request
				next_s.ack = 1'b0;
				next_s.err = 1'b0;
				next_s.data_oe_b = 1'b1;
				next_s.bus_req = 1'b0;
				next_s.idle_req = 1'b0;
				next_s.state = SY_DONE;
			end
			SY_DONE: begin
				next_s.done = 1'b1;
				next_s.state = SY_IDLE;
			end
			default: next_s.state = SY_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s <= '0;
			s.data_oe_b <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign bus.sys_data = s.data_out;
	assign bus.sys_check = s.check_out;
	assign bus.sys_data_oe_b = s.data_oe_b;
	assign bus.data_bus_req = s.bus_req;
	assign bus.fill_warning = s.warn;
	assign bus.fill_miss_select = s.sel;
	assign bus.fill_error = s.err;
	assign bus.fill_nocheck = s.nocheck;
	assign bus.data_ack = s.ack;
	assign bus.cache_idle_request = s.idle_req;
	assign beat_num = s.beat;
	assign fill_busy = s.busy;
	assign fill_done = s.done;
endmodule : fill_sys_end

// File: testbench/fill_bus_chk.sv
// Concurrent checks on the fill bus joining the processor end and the system end
`timescale 1ns/1ns
module fill_bus_chk
	import fill_bus_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Bus wires seen on the interface
	input wire logic data_bus_req,
	input wire logic dev_data_oe_b,
	input wire logic fill_warning,
	input wire logic data_ack,
	input wire logic cache_idle_request,
	input wire logic data_ram_oe,
	input wire logic data_ram_we,
	input wire logic [INDEX_W-1:0] cache_index
);
	// ----------------------------------------------------------------
	// Sequences
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Fill write cycle that the system did not acknowledge
	sequence s_fill_refused;
		data_ram_we && dev_data_oe_b && !data_ack;
	endsequence
	// One quiet cycle, then the write starts over
	sequence s_retry;
		!data_ram_we ##1 data_ram_we;
	endsequence
	// A plain cache read or write leaves idle
	sequence s_cache_start;
		$rose(data_ram_oe) || ($rose(data_ram_we) && !dev_data_oe_b);
	endsequence
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	AST_BUS_RELEASE: assert property (data_bus_req |=> dev_data_oe_b)
		else $error("processor kept the data bus after a request");
	AST_BUS_DRIVE: assert property (!data_bus_req |=> !dev_data_oe_b)
		else $error("processor left the data bus without a request");
	AST_FILL_WRITE: assert property (fill_warning |=> data_ram_we && dev_data_oe_b)
		else $error("fill write did not start one edge after the warning");
	AST_FILL_RETRY: assert property (s_fill_refused |=> s_retry)
		else $error("refused fill cycle not retried after one clock");
	AST_INDEX_STEP: assert property (data_ram_we && dev_data_oe_b && data_ack
		|=> !data_ram_we || cache_index == $past(cache_index) + 22'h1)
		else $error("fill index did not step after an accepted cycle");
	AST_IDLE_HOLD: assert property (s_cache_start |-> !$past(cache_idle_request))
		else $error("cache operation started under an idle request");
	AST_READ_PULSE: assert property (data_ram_oe |-> !data_ram_we ##1 !data_ram_oe)
		else $error("read enable not a lone one-cycle pulse");
	AST_WRITE_ALONE: assert property (data_ram_we |-> !data_ram_oe)
		else $error("write enable raised beside read enable");
endmodule : fill_bus_chk

// File: testbench/bcache_fill_data_bus_control_tb.sv
// Self-checking bench for the processor end facing the system end
`timescale 1ns/1ns
module bcache_fill_data_bus_control_tb;
	import fill_bus_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [4:0] reg_addr = 5'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic reg_wr = 1'b0, reg_rd = 1'b0, cache_rd_req = 1'b0, cache_wr_req = 1'b0;
	logic [INDEX_W-1:0] op_index = '0, first_idx;
	logic [DATA_W-1:0] op_wdata = '0, cache_data, beat_data;
	logic fill_go = 1'b0, fill_slot = 1'b0, fill_bad = 1'b0, skip_check = 1'b0;
	logic ecc_mode = 1'b0, beat_stall = 1'b0, masked = 1'b0, seen_we, stalled;
	logic irq, op_ack, cache_data_valid, fill_data_valid, check_error, machine_check_trap;
	logic fill_busy, fill_done;
	logic [1:0] beat_num;
	int n_mismatch = 0, check_count = 0, n_valid, n_trap, n_err;
	logic [INDEX_W-1:0] miss [2] = '{22'h2A5F3C, 22'h3FFFFF};
	// Rows: slot, bad (expected traps), skip, system code, processor code, stall
	logic [5:0] rows [6] = '{6'h00, 6'h26, 6'h11, 6'h24, 6'h2C, 6'h1B};
	// ----------------------------------------------------------------
	// Design under test
	// ----------------------------------------------------------------
	fill_bus_if fill_bus_if_i();
	cache_fill_ctrl cache_fill_ctrl_i (.clk, .rst_b, .bus(fill_bus_if_i), .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .irq, .cache_rd_req, .cache_wr_req, .op_index, .op_wdata,
		.op_ack, .cache_data, .cache_data_valid, .fill_data_valid, .check_error,
		.machine_check_trap);
	fill_sys_end fill_sys_end_i (.clk, .rst_b, .bus(fill_bus_if_i), .fill_go, .fill_slot,
		.fill_bad, .skip_check, .ecc_mode, .beat_stall, .beat_data, .beat_num, .fill_busy,
		.fill_done);
	fill_bus_chk fill_bus_chk_i (.clk, .rst_b, .data_bus_req(fill_bus_if_i.data_bus_req),
		.dev_data_oe_b(fill_bus_if_i.dev_data_oe_b), .fill_warning(fill_bus_if_i.fill_warning),
		.data_ack(fill_bus_if_i.data_ack), .cache_idle_request(fill_bus_if_i.cache_idle_request),
		.data_ram_oe(fill_bus_if_i.data_ram_oe), .data_ram_we(fill_bus_if_i.data_ram_we),
		.cache_index(fill_bus_if_i.cache_index));
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [DATA_W-1:0] bd(input logic [1:0] n);
		return {64{n}} ^ {4{32'h5A3C96F1}};
	endfunction : bd
	function automatic logic [CHECK_W-1:0] code(input logic [DATA_W-1:0] d, input logic ecc);
		logic [CHECK_W-1:0] c;
		for (int i = 0; i < CHECK_W; i++) begin
			c[i] = ecc ? ^(d[64*(i/8) +: 64] & ECC_MASK[i%8]) : ^d[8*i +: 8];
		end
		return c;
	endfunction : code
	task automatic cmp(input string nm, input logic [143:0] exp, input logic [143:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : cmp
	task automatic conclude();
		if (n_mismatch == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [31:0] exp);
		@(posedge clk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		cmp("reg read", exp, reg_rdata);
	endtask : rd
	task automatic rst_chk();
		cmp("reset outputs", 7'h03, {irq, op_ack, machine_check_trap, fill_bus_if_i.data_ram_we,
			fill_bus_if_i.data_ram_oe, fill_bus_if_i.dev_data_oe_b, fill_bus_if_i.sys_data_oe_b});
	endtask : rst_chk
	// Cache write or read outside fills
	task automatic op(input logic w, input logic [21:0] i, input logic [127:0] d, input logic e);
		@(posedge clk);
		{cache_wr_req, cache_rd_req, op_index, op_wdata} <= {w, !w, i, d};
		@(posedge clk);
		{cache_wr_req, cache_rd_req} <= 2'b00;
		@(posedge clk);
		cmp("op ack", 1, op_ack);
		cmp("ram enables", {w, !w}, {fill_bus_if_i.data_ram_we, fill_bus_if_i.data_ram_oe});
		cmp("op index", i, fill_bus_if_i.cache_index);
		if (w) cmp("write word", {code(d, e), d}, {fill_bus_if_i.check, fill_bus_if_i.data});
		@(posedge clk);
		if (!w) cmp("read valid", 1, cache_data_valid);
	endtask : op
	// One fill from the system end, then its results and status
	task automatic fill(input logic [5:0] r);
		int k;
		int e;
		{fill_slot, fill_bad, skip_check, ecc_mode, beat_stall} <= {r[5:2], r[0]};
		wr(REG_CTRL, {31'h0, r[1]});
		{n_valid, n_trap, n_err, seen_we, stalled} = '0;
		fill_go <= 1'b1;
		k = 0;
		while (fill_done !== 1'b1 && k < 80) begin
			@(posedge clk);
			if (fill_busy) fill_go <= 1'b0;
			k++;
		end
		e = r[3] ? 0 : int'(code(bd(2'h0), r[2]) != code(bd(2'h0), r[1]))
			+ int'(code(bd(2'h1), r[2]) != code(bd(2'h1), r[1]));
		repeat (2) @(posedge clk);
		cmp("fill ended", 1, k < 80);
		cmp("beats", 2, n_valid);
		cmp("traps", r[4], n_trap);
		cmp("check errors", e, n_err);
		cmp("fill index", miss[r[5]], first_idx);
		cmp("retry seen", r[0], stalled);
		cmp("irq", !masked, irq);
		rd(REG_STATUS, {29'h0, 1'b1, e != 0, r[4]});
		rd(REG_STATUS, 32'h0);
	endtask : fill
	// ----------------------------------------------------------------
	// Clock, monitor and watchdog
	// ----------------------------------------------------------------
	assign beat_data = bd(beat_num);
	initial begin
		forever #5 clk = ~clk;
	end
	// Count fill events and check every acknowledged system data cycle on the wire
	always @(posedge clk) begin
		if (fill_data_valid) begin
			cmp("fill data", bd(n_valid[1:0]), cache_data);
			n_valid++;
		end
		n_trap += int'(machine_check_trap === 1'b1);
		n_err += int'(check_error === 1'b1);
		if (fill_bus_if_i.data_ram_we && fill_bus_if_i.dev_data_oe_b) begin
			if (!seen_we) first_idx = fill_bus_if_i.cache_index;
			seen_we = 1'b1;
			if (!fill_bus_if_i.data_ack) begin
				stalled = 1'b1;
				beat_stall <= 1'b0;
			end
		end
		if (fill_bus_if_i.data_ack && !fill_bus_if_i.sys_data_oe_b)
			cmp("check lines", code(fill_bus_if_i.data, ecc_mode), fill_bus_if_i.check);
	end
	initial begin
		#200000;
		n_mismatch++;
		conclude();
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		rst_chk();
		rst_b <= 1'b1;
		wr(REG_MISS0, {6'h0, miss[0], 4'h0});
		wr(REG_MISS1, {6'h0, miss[1], 4'h0});
		wr(REG_MASK, 32'h7);
		wr(5'h1C, 32'hFFFFFFFF);
		rd(5'h1C, 32'h0);
		for (int e = 0; e < 2; e++) begin
			wr(REG_CTRL, e);
			op(1'b1, 22'h3FFFFF, bd(e[1:0]), e[0]);
			op(1'b0, 22'h000001, '0, e[0]);
		end
		foreach (rows[i]) fill(rows[i]);
		// Masked fill while a read waits behind the idle request
		masked = 1'b1;
		wr(REG_MASK, 32'h0);
		fork
			fill(rows[1]);
			begin
				while (fill_bus_if_i.cache_idle_request !== 1'b1) @(posedge clk);
				cache_rd_req <= 1'b1;
				while (op_ack !== 1'b1) @(posedge clk);
				cache_rd_req <= 1'b0;
				cmp("read held off", 2, n_valid);
			end
		join
		// Second reset in mid-run
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_chk();
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		conclude();
	end
endmodule : bcache_fill_data_bus_control_tb
